// *** src/adc_conversion_sequencer.sv ***
// Digital control of an eight-input sampling converter: conversion timing,
// select capture, channel scan, output clamp, serial readout, AXI4-Lite.
// Assumes pins arrive asynchronously and the analog core code is on clock.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"
module adc_conversion_sequencer (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic conv_start_i,
    input wire logic sclk_i,
    input wire logic power_down_n_i,
    input wire logic low_power_select_i,
    input wire logic scan_enable_i,
    input wire logic [2:0] chan_sel_i,
    input wire logic [2:0] gain_sel_i,
    input wire logic signed [15:0] raw_code_i,
    input wire adc_seq_pkg::axi_req_t axi_req_i,
    output adc_seq_pkg::axi_rsp_t axi_rsp_o,
    output logic busy_o,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic sample_o,
    output logic [2:0] mux_chan_o,
    output logic [2:0] mux_gain_o,
    output logic amp_bypass_o
);
    adc_seq_pkg::state_t q;
    adc_seq_pkg::state_t n;
    logic cs_now;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic scan_now;
    logic scan_rise;
    logic scan_fall;
    logic lp;
    logic pd_ok;
    logic bipolar_clamp;
    logic [13:0] code;
    logic [2:0] chan_pick;

    // Edges are found only on the second synchroniser stage.
    assign cs_now = q.s2[`PIN_CS];
    assign cs_rise = cs_now & ~q.cs_d;
    assign cs_fall = ~cs_now & q.cs_d;
    assign sclk_rise = q.s2[`PIN_SCLK] & ~q.sclk_d;
    assign scan_now = q.s2[`PIN_SCAN];
    assign scan_rise = scan_now & ~q.scan_d;
    assign scan_fall = ~scan_now & q.scan_d;
    assign lp = q.s2[`PIN_LP];
    assign pd_ok = q.s2[`PIN_PD];

    // Clamp selection; gain code zero is unity gain.
    assign bipolar_clamp = ~q.ctrl[`CTRL_UNIPOLAR]
        & ~q.ctrl[`CTRL_AMP_BYPASS] & (q.mux_gain != 3'h0);

    // Output code from the core value with the digital clamp applied.
    always_comb
    begin
        code = raw_code_i[13:0];
        if (bipolar_clamp)
        begin
            if (raw_code_i > 16'sh1fff)
                code = `CODE_POS_MAX;
            else if (raw_code_i < -16'sh2000)
                code = `CODE_NEG_MIN;
        end
        else if (q.ctrl[`CTRL_UNIPOLAR] && raw_code_i < 16'sh0000)
        begin
            code = 14'h0000;
        end
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        n = q;
        chan_pick = q.s2[`PIN_CHAN_HI:`PIN_CHAN_LO];
        n.s1 = {conv_start_i, sclk_i, power_down_n_i, low_power_select_i,
            scan_enable_i, chan_sel_i, gain_sel_i};
        n.s2 = q.s1;
        n.cs_d = q.s2[`PIN_CS];
        n.sclk_d = q.s2[`PIN_SCLK];
        n.scan_d = q.s2[`PIN_SCAN];
        n.sample = 1'b0;

        // Scan window edges restart or close the sequence.
        if (scan_rise)
        begin
            n.seq_pos = 3'h0;
            n.seq_init = 1'b1;
            n.scan_tail = 1'b0;
        end
        if (scan_fall)
            n.scan_tail = 1'b1;

        // Select capture on the start rising edge.
        if (cs_rise && pd_ok)
        begin
            if (scan_now)
            begin
                chan_pick = n.seq_pos;
                if (!(lp && n.seq_init))
                    n.seq_pos = n.seq_pos + 3'h1;
                n.seq_init = 1'b0;
            end
            else if (n.scan_tail)
            begin
                chan_pick = n.seq_pos;
                n.scan_tail = 1'b0;
            end
            n.lat_chan = chan_pick;
            n.lat_gain = q.s2[`PIN_GAIN_HI:`PIN_GAIN_LO];
            if (lp)
            begin
                n.app_chan = chan_pick;
                n.app_gain = q.s2[`PIN_GAIN_HI:`PIN_GAIN_LO];
            end
            else
            begin
                n.app_chan = q.lat_chan;
                n.app_gain = q.lat_gain;
            end
        end

        // Conversion phases; power-down halts conversion and readout, the register bus still runs.
        if (!pd_ok)
        begin
            n.phase = adc_seq_pkg::ST_DOWN;
            n.busy = 1'b0;
        end
        else
        begin
            case (q.phase)
                adc_seq_pkg::ST_DOWN:
                    n.phase = adc_seq_pkg::ST_IDLE;
                adc_seq_pkg::ST_IDLE, adc_seq_pkg::ST_READ:
                begin
                    if (cs_fall)
                    begin
                        n.phase = adc_seq_pkg::ST_CONV;
                        n.busy = 1'b1;
                        n.sample = 1'b1;
                        n.mux_chan = q.app_chan;
                        n.mux_gain = q.app_gain;
                        n.cnt = q.ctrl[`CTRL_AMP_BYPASS] ?
                            6'(`CONV_BYP_CYC) : 6'(`CONV_AMP_CYC);
                    end
                    else if (sclk_rise && !cs_now)
                    begin
                        n.shreg = {q.shreg[`SHIFT_W-2:0], 1'b0};
                    end
                end
                adc_seq_pkg::ST_CONV:
                begin
                    if (q.cnt == 6'h01)
                    begin
                        n.busy = 1'b0;
                        n.phase = adc_seq_pkg::ST_READ;
                        n.result = code;
                        n.shreg = {code, q.mux_chan, q.mux_gain};
                    end
                    else
                    begin
                        n.cnt = q.cnt - 6'h01;
                    end
                end
                default:
                    n.phase = adc_seq_pkg::ST_IDLE;
            endcase
        end
        n.sdo = n.shreg[`SHIFT_W-1];
        n.sdo_oe = pd_ok & ~cs_now;

        // Write channels: address and data in either order.
        if (axi_req_i.awvalid && q.rsp.awready)
        begin
            n.aw_got = 1'b1;
            n.waddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && q.rsp.wready)
        begin
            n.w_got = 1'b1;
            n.wdata = axi_req_i.wdata;
            n.wstrb = axi_req_i.wstrb;
        end
        if (q.rsp.bvalid && axi_req_i.bready)
            n.rsp.bvalid = 1'b0;
        if (n.aw_got && n.w_got && !q.rsp.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = `RESP_SLVERR;
            if (n.waddr == `REG_CTRL)
            begin
                n.rsp.bresp = `RESP_OKAY;
                if (n.wstrb[0])
                    n.ctrl = n.wdata[1:0];
            end
        end
        n.rsp.awready = ~n.aw_got & ~n.rsp.bvalid;
        n.rsp.wready = ~n.w_got & ~n.rsp.bvalid;

        // Read channel: one outstanding read, answered next cycle.
        if (q.rsp.rvalid && axi_req_i.rready)
            n.rsp.rvalid = 1'b0;
        if (axi_req_i.arvalid && q.rsp.arready)
        begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rresp = `RESP_OKAY;
            case (axi_req_i.araddr)
                `REG_CTRL:
                    n.rsp.rdata = {30'h0000_0000, q.ctrl};
                `REG_STATUS:
                    n.rsp.rdata = {19'h0_0000, q.phase, q.seq_pos, scan_now,
                        q.busy, q.mux_gain, q.mux_chan};
                `REG_RESULT:
                    n.rsp.rdata = {18'h0_0000, q.result};
                default:
                begin
                    n.rsp.rdata = 32'h0000_0000;
                    n.rsp.rresp = `RESP_SLVERR;
                end
            endcase
        end
        n.rsp.arready = ~n.rsp.rvalid;
    end

    // State register; everything resets to zero, control to its default.
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
            q.ctrl <= `CTRL_RESET;
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs come straight from the state register.
    assign axi_rsp_o = q.rsp;
    assign busy_o = q.busy;
    assign sdo_o = q.sdo;
    assign sdo_oe_o = q.sdo_oe;
    assign sample_o = q.sample;
    assign mux_chan_o = q.mux_chan;
    assign mux_gain_o = q.mux_gain;
    assign amp_bypass_o = q.ctrl[`CTRL_AMP_BYPASS];

    // Checks of the conversion and sequencing behaviour.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_busy_rise_delay: assert property (
        (q.phase == adc_seq_pkg::ST_IDLE || q.phase == adc_seq_pkg::ST_READ)
        && cs_fall && pd_ok
        |=> q.busy && q.sample)
        else $error("busy did not rise after start fell");
    a_conv_bypass_time: assert property (
        $rose(q.busy) && q.ctrl[`CTRL_AMP_BYPASS] |-> ##[1:13] !q.busy)
        else $error("bypassed conversion too long");
    a_conv_amp_time: assert property (
        $rose(q.busy) |-> ##[1:31] !q.busy)
        else $error("amplified conversion too long");
    a_status_bit_order: assert property (
        $fell(q.busy) && q.phase == adc_seq_pkg::ST_READ
        |-> q.shreg[5:0] == {q.mux_chan, q.mux_gain} && q.sdo == q.result[13])
        else $error("readout word misordered");
    a_bipolar_clamp_top: assert property (
        $fell(q.busy) && q.phase == adc_seq_pkg::ST_READ
        && $past(bipolar_clamp)
        && $past(raw_code_i) > 16'sh1fff |-> q.result == `CODE_POS_MAX)
        else $error("bipolar code not saturated");
    a_unipolar_zero_clamp: assert property (
        $fell(q.busy) && q.phase == adc_seq_pkg::ST_READ
        && $past(q.ctrl[`CTRL_UNIPOLAR])
        && $past(raw_code_i) < 16'sh0000 |-> q.result == 14'h0000)
        else $error("unipolar code below zero");
    a_seq_wrap_step: assert property (
        cs_rise && pd_ok && scan_now && !scan_rise && !(lp && q.seq_init)
        && q.seq_pos == 3'h7 |=> q.seq_pos == 3'h0)
        else $error("sequencer did not wrap");
    a_seq_restart_zero: assert property (
        scan_rise |=> q.seq_pos == 3'h0 || $past(cs_rise))
        else $error("sequencer did not restart");
    a_normal_one_delay: assert property (
        cs_rise && pd_ok && !lp |=> q.app_chan == $past(q.lat_chan))
        else $error("normal mode select not delayed");
    a_lp_same_sample: assert property (
        cs_rise && pd_ok && lp && !scan_now && !q.scan_tail && !scan_fall
        |=> q.app_chan == $past(q.s2[`PIN_CHAN_HI:`PIN_CHAN_LO]))
        else $error("low power select not applied");
    a_scan_tail_chan: assert property (
        cs_rise && pd_ok && !scan_now && q.scan_tail
        |=> q.lat_chan == $past(q.seq_pos) && !q.scan_tail)
        else $error("post-scan channel wrong");

    c_scan_wrap: cover property (scan_now && q.seq_pos == 3'h7 ##1 cs_rise);
    c_lp_convert: cover property (lp && $fell(q.busy));
    c_clamp_hit: cover property ($fell(q.busy)
        && q.result == `CODE_NEG_MIN && bipolar_clamp);
    c_scan_tail: cover property (q.scan_tail ##1 !q.scan_tail);
endmodule

// *** src/adc_seq_consts.svh ***
// Constants for the conversion sequencer: pin slots, register map, timing.
// Assumes a 50 ns core clock; included by the package and the design.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 50
`define BUSY_RISE_NS 30
`define CONV_BYP_NS 660
`define CONV_AMP_NS 1550
`define CONV_BYP_CYC ((`CONV_BYP_NS) / (`CLK_PERIOD_NS))
`define CONV_AMP_CYC ((`CONV_AMP_NS) / (`CLK_PERIOD_NS))
`define PIN_W 11
`define PIN_CS 10
`define PIN_SCLK 9
`define PIN_PD 8
`define PIN_LP 7
`define PIN_SCAN 6
`define PIN_CHAN_HI 5
`define PIN_CHAN_LO 3
`define PIN_GAIN_HI 2
`define PIN_GAIN_LO 0
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESULT 8'h08
`define CTRL_UNIPOLAR 0
`define CTRL_AMP_BYPASS 1
`define CTRL_RESET 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CODE_POS_MAX 14'h1fff
`define CODE_NEG_MIN 14'h2000
`define SHIFT_W 20
`endif

// *** src/adc_seq_pkg.sv ***
// Types shared by the conversion sequencer: bus carriers, phases, state.
// Assumes adc_seq_consts.svh is on the include path.
`include "adc_seq_consts.svh"
package adc_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_READ = 2'b10,
        ST_DOWN = 2'b11
    } phase_t;
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;
    typedef struct packed {
        logic [`PIN_W-1:0] s1;
        logic [`PIN_W-1:0] s2;
        logic cs_d;
        logic sclk_d;
        logic scan_d;
        phase_t phase;
        logic [5:0] cnt;
        logic busy;
        logic sdo;
        logic sdo_oe;
        logic sample;
        logic [`SHIFT_W-1:0] shreg;
        logic [2:0] lat_chan;
        logic [2:0] lat_gain;
        logic [2:0] app_chan;
        logic [2:0] app_gain;
        logic [2:0] mux_chan;
        logic [2:0] mux_gain;
        logic [2:0] seq_pos;
        logic seq_init;
        logic scan_tail;
        logic [13:0] result;
        logic [1:0] ctrl;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        axi_rsp_t rsp;
    } state_t;
endpackage

// *** tb/ctrl_model.sv ***
// Controller model: drives convert start and the serial clock, reads data.
// Assumes frames are run one at a time, paced by the core clock.
`timescale 1ns/1ns
module ctrl_model (
    input wire logic core_clk_i,
    input wire logic busy_i,
    input wire logic sdo_i,
    output logic cs_o,
    output logic sclk_o
);
    // Start is held low at power-up and the serial clock stands still.
    initial
    begin
        cs_o = 1'b0;
        sclk_o = 1'b0;
    end

    // One frame: acquire, convert, then shift n bits out msb first.
    task automatic frame(input int n, output logic [19:0] w,
        output int rise, output int busy);
        begin
            w = '0;
            rise = 0;
            busy = 0;
            @(posedge core_clk_i);
            cs_o <= 1'b1;
            sclk_o <= 1'b0;
            repeat (11) @(posedge core_clk_i);
            cs_o <= 1'b0;
            while (busy_i !== 1'b1 && rise < 9)
            begin
                @(posedge core_clk_i);
                rise++;
            end
            while (busy_i === 1'b1 && busy < 40)
            begin
                @(posedge core_clk_i);
                busy++;
            end
            // The top bit is read as busy falls, then one bit per rise.
            for (int i = 0; i < n; i++)
            begin
                w = {w[18:0], sdo_i};
                sclk_o <= 1'b1;
                repeat (4) @(posedge core_clk_i);
                if (i < n - 1)
                begin
                    sclk_o <= 1'b0;
                    repeat (4) @(posedge core_clk_i);
                end
            end
        end
    endtask
endmodule

// *** tb/adc_conversion_sequencer_tb_top.sv ***
// Self-checking bench for the sequencer: register bus and link frames.
// Assumes the design, its package and the controller model are compiled.
`timescale 1ns/1ns
module adc_conversion_sequencer_tb_top;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic lp = 1'b0;
    logic scan = 1'b0;
    logic [2:0] chan = 3'h0;
    logic [2:0] gain = 3'h0;
    logic signed [15:0] raw = 16'h0000;
    adc_seq_pkg::axi_req_t req = '0;
    adc_seq_pkg::axi_rsp_t rsp;
    logic busy;
    logic sdo;
    logic cs;
    logic sclk;
    logic [2:0] mux_chan;
    logic [2:0] mux_gain;
    logic sample;
    logic oe;
    logic bypass;
    int samples = 0;
    logic [19:0] w;
    logic [1:0] r;
    logic [31:0] d;
    int rise;
    int bcyc;
    int failures = 0;
    int cmp_count = 0;
    // Clamp cases: ctrl, gain code, core code, expected output code.
    logic [1:0] cl_ctrl [6] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};
    logic [2:0] cl_gain [6] = '{3'h1, 3'h7, 3'h0, 3'h3, 3'h5, 3'h7};
    logic [15:0] cl_raw [6] = '{16'h2328, 16'hdcd8, 16'h2328, 16'h2328,
        16'hfffb, 16'h2328};
    logic [13:0] cl_exp [6] = '{14'h1fff, 14'h2000, 14'h2328, 14'h2328,
        14'h0000, 14'h2328};
    // Scan plan: bit 3 scan enable, bits 2:0 expected readout channel.
    // The last five entries run in normal mode, the rest in low power.
    logic [3:0] plan [19] = '{4'h8, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
        4'he, 4'hf, 4'h8, 4'h1, 4'h6, 4'h8, 4'h8, 4'h0, 4'h1, 4'he, 4'h8,
        4'h9};

    // Device under test with power-down held inactive.
    adc_conversion_sequencer adc_conversion_sequencer_inst (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .conv_start_i(cs), .sclk_i(sclk), .power_down_n_i(1'b1),
        .low_power_select_i(lp), .scan_enable_i(scan),
        .chan_sel_i(chan), .gain_sel_i(gain), .raw_code_i(raw),
        .axi_req_i(req), .axi_rsp_o(rsp), .busy_o(busy), .sdo_o(sdo),
        .sdo_oe_o(oe), .sample_o(sample), .mux_chan_o(mux_chan),
        .mux_gain_o(mux_gain), .amp_bypass_o(bypass)
    );

    // Far-side controller.
    ctrl_model ctrl_model_inst (
        .core_clk_i(core_clk_i), .busy_i(busy), .sdo_i(sdo),
        .cs_o(cs), .sclk_o(sclk)
    );

    // Core clock, 50 ns period.
    always #25 core_clk_i = ~core_clk_i;

    // Sampling pulses from the design; each frame must give exactly one.
    always @(posedge core_clk_i)
        if (sample === 1'b1)
            samples <= samples + 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        begin
            cmp_count++;
            if (got !== exp)
            begin
                failures++;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    task automatic stop_test;
        begin
            if (failures == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task automatic timeout;
        begin
            failures++;
            stop_test();
        end
    endtask

    // Write one word; address and data offered together, each released.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        begin
            @(posedge core_clk_i);
            req.awvalid <= 1'b1;
            req.awaddr <= a;
            req.wvalid <= 1'b1;
            req.wdata <= v;
            req.wstrb <= 4'hf;
            req.bready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge core_clk_i);
                if (req.awvalid && rsp.awready)
                    req.awvalid <= 1'b0;
                if (req.wvalid && rsp.wready)
                    req.wvalid <= 1'b0;
                if (rsp.bvalid === 1'b1)
                    break;
            end
            r = rsp.bresp;
            req.bready <= 1'b0;
            if (n == 50)
                timeout();
        end
    endtask

    // Read one word; rready held until the data are seen.
    task automatic axi_rd(input logic [7:0] a);
        int n;
        begin
            @(posedge core_clk_i);
            req.arvalid <= 1'b1;
            req.araddr <= a;
            req.rready <= 1'b1;
            for (n = 0; n < 50; n++)
            begin
                @(posedge core_clk_i);
                if (req.arvalid && rsp.arready)
                    req.arvalid <= 1'b0;
                if (rsp.rvalid === 1'b1)
                    break;
            end
            d = rsp.rdata;
            r = rsp.rresp;
            req.rready <= 1'b0;
            if (n == 50)
                timeout();
        end
    endtask

    // One frame with the timing of busy checked against its bound.
    task automatic run(input int n, input int mx);
        int s0;
        begin
            s0 = samples;
            ctrl_model_inst.frame(n, w, rise, bcyc);
            if (rise > 8)
                timeout();
            check(32'(rise <= 5), 32'h1);
            check(32'(bcyc > 0 && bcyc <= mx), 32'h1);
            check(32'(samples - s0), 32'h1);
            check(32'(oe), 32'h1);
        end
    endtask

    // Main sequence: registers, normal mode, low power, clamp, scan.
    initial
    begin
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        axi_rd(8'h00);
        check(d, 32'h0);
        axi_wr(8'h04, 32'h3);
        check(32'(r), 32'h2);
        axi_rd(8'h10);
        check({d[29:0], r}, 32'h2);
        axi_wr(8'h00, 32'h2);
        axi_rd(8'h00);
        check(d, 32'h2);
        check(32'(bypass), 32'h1);
        chan <= 3'h2;
        gain <= 3'h1;
        raw <= 16'h0123;
        run(20, 13);
        chan <= 3'h5;
        gain <= 3'h4;
        run(20, 13);
        check(32'(w[5:0]), 32'h11);
        check(32'(w[19:6]), 32'h123);
        chan <= 3'h0;
        gain <= 3'h0;
        run(14, 13);
        check(32'(w[13:0]), 32'h123);
        check(32'(mux_chan), 32'h5);
        check(32'(mux_gain), 32'h4);
        axi_rd(8'h04);
        check(d, 32'h1025);
        axi_rd(8'h08);
        check(d, 32'h123);
        lp <= 1'b1;
        run(20, 13);
        chan <= 3'h3;
        gain <= 3'h6;
        run(20, 13);
        check(32'(w[5:0]), 32'h1e);
        for (int i = 0; i < 6; i++)
        begin
            axi_wr(8'h00, 32'(cl_ctrl[i]));
            gain <= cl_gain[i];
            raw <= cl_raw[i];
            run(20, cl_ctrl[i][1] ? 13 : 31);
            check(32'(w[19:6]), 32'(cl_exp[i]));
            check(32'(w[2:0]), 32'(cl_gain[i]));
            check(32'(bypass), 32'(cl_ctrl[i][1]));
        end
        axi_wr(8'h00, 32'h2);
        chan <= 3'h6;
        for (int i = 0; i < 19; i++)
        begin
            scan <= plan[i][3];
            lp <= (i < 14);
            repeat (2) @(posedge core_clk_i);
            run(20, 13);
            check(32'(w[5:3]), 32'(plan[i][2:0]));
        end
        stop_test();
    end
endmodule
